// >>> verilog/brc_pkg.sv
// Offsets, reset values and field positions of the rail control registers
package brc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RAIL3_DECAY_OFFS = 8'h22;
  localparam logic [7:0] RAIL3_NORMAL_VOLTAGE_OFFS = 8'h23;
  localparam logic [7:0] RAIL3_SLEEP_CONTROL_OFFS = 8'h24;
  localparam logic [7:0] RAIL4_CONTROL_OFFS = 8'h25;
  localparam logic [7:0] RAIL5_CONTROL_OFFS = 8'h26;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RAIL3_DECAY_RST = 8'h70;
  localparam logic [7:0] RAIL3_NORMAL_VOLTAGE_RST = 8'h70;
  localparam logic [7:0] RAIL3_SLEEP_CONTROL_RST = 8'h70;
  localparam logic [5:0] RAIL_CONTROL_RST = 6'h0d;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 1;
  localparam int RAIL3_SLEEP_ENABLE_BIT = 0;
  localparam int RAIL3_DECAY_BIT = 0;
  localparam int SLEEP_ENABLE_MSB = 5;
  localparam int SLEEP_ENABLE_LSB = 4;
  localparam int CODE_USE_MSB = 3;
  localparam int CODE_USE_LSB = 2;
  localparam int OPERATING_MODE_BIT = 1;
  localparam int ON_CONTROL_BIT = 0;
  localparam logic [1:0] CODE_USE_KEEP = 2'h3;
  localparam logic [1:0] SLEEP_DISABLED = 2'h0;
  localparam int NUM_CTL_RAILS = 2;

endpackage

// >>> verilog/brc_sync.sv
// Two-flop synchroniser for pin levels
module brc_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i, // Device clock
  input wire logic rst_i, // Async reset, active high
  input wire logic [WIDTH-1:0] d_i, // Asynchronous levels
  output logic [WIDTH-1:0] q_o // Synchronised levels
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule

// >>> verilog/brc_rail_regs.sv
// Rail three to five control register bank with sleep code copy
// Behaviour
// RULE1: Rail three normal code in bits 7-1 at 0x23, resets to 38h.
// RULE2: Rail three sleep code in bits 7-1 at 0x24, resets to 38h.
// RULE3: On sleep entry the sleep code is copied into the normal code.
// RULE4: Bit 0 at 0x24 enables rail three sleep, pin chosen by factory.
// RULE5: Rail four sleep enable bits 5-4 at 0x25; any nonzero enables.
// RULE6: Host keeps bits 3-2 at 0x25 at 3h, else codes ignored.
// RULE7: Bit 1 at 0x25 picks rail four automatic or forced PWM mode.
// RULE8: Bit 0 at 0x25 zero turns rail four off whatever the pins say.
// RULE9: Rail five sleep enable bits 5-4 at 0x26; any nonzero enables.
// RULE10: Host keeps bits 3-2 at 0x26 at 3h, else codes ignored.
// RULE11: Bit 1 at 0x26 picks rail five automatic or forced PWM mode.
// RULE12: Bit 0 at 0x26 zero turns rail five off whatever the pins say.
// RULE13: Rail three decay bit: 0 slews down, 1 decays with load.
// RULE14: Reserved upper bits of rail four and five registers read zero.
// RULE15: Reserved bit 0 at 0x23 stores and reads back, resets zero.
module brc_rail_regs
  import brc_pkg::*;
(
  input wire logic clk_i, // Device clock, 25 MHz
  input wire logic rst_i, // Async reset, active high
  input wire logic wr_en_i, // Register write strobe
  input wire logic rd_en_i, // Register read strobe
  input wire logic [7:0] addr_i, // Register offset
  input wire logic [7:0] wdata_i, // Write data
  input wire logic sleep_pin_a_i, // Sleep pin a, high requests sleep
  input wire logic sleep_pin_b_i, // Sleep pin b, high requests sleep
  input wire logic [2:0] sleep_pin_sel_i, // Factory pin choice, rails 3..5
  input wire logic [1:0] rail_seq_on_i, // Sequencer on request, rails 4..5
  output logic [7:0] rdata_o, // Read data, valid cycle after rd_en_i
  output logic [6:0] rail3_voltage_code_o, // Rail three active code
  output logic rail3_sleep_o, // Rail three in sleep
  output logic rail3_decay_select_o, // Rail three decay select
  output logic [1:0] rail_sleep_o, // Rails 4..5 in sleep
  output logic [1:0] rail_pwm_o, // Rails 4..5 forced PWM
  output logic [1:0] rail_on_o, // Rails 4..5 enabled
  output logic [1:0] rail_code_ignored_o // Rails 4..5 codes ignored
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [1:0] pin_sync;

  brc_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({sleep_pin_b_i, sleep_pin_a_i}),
    .q_o(pin_sync)
  );

  // ----------------------------------------------------------------
  // Rail three registers
  // ----------------------------------------------------------------
  logic [7:0] decay_ff;
  logic [7:0] normal_ff;
  logic [7:0] sleep_ctl_ff;
  logic rail3_asleep_ff;
  logic rail3_sleep_req;
  logic rail3_enter;
  logic wr_decay;
  logic wr_normal;
  logic wr_sleep;

  assign wr_decay = wr_en_i && (addr_i == RAIL3_DECAY_OFFS);
  assign wr_normal = wr_en_i && (addr_i == RAIL3_NORMAL_VOLTAGE_OFFS);
  assign wr_sleep = wr_en_i && (addr_i == RAIL3_SLEEP_CONTROL_OFFS);

  // Factory choice picks the pin; the enable bit gates it
  assign rail3_sleep_req = sleep_ctl_ff[RAIL3_SLEEP_ENABLE_BIT] &&
                           (sleep_pin_sel_i[0] ? pin_sync[1] : pin_sync[0]); // RULE4
  assign rail3_enter = rail3_sleep_req && !rail3_asleep_ff;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      decay_ff <= RAIL3_DECAY_RST;
    else if (wr_decay)
      decay_ff <= wdata_i; // RULE13
  end

  // Sleep entry copy beats a same-cycle host write of the code field
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      normal_ff <= RAIL3_NORMAL_VOLTAGE_RST; // RULE1
    else
    begin
      if (rail3_enter)
        normal_ff[CODE_MSB:CODE_LSB] <= sleep_ctl_ff[CODE_MSB:CODE_LSB]; // RULE3
      else if (wr_normal)
        normal_ff[CODE_MSB:CODE_LSB] <= wdata_i[CODE_MSB:CODE_LSB]; // RULE1
      if (wr_normal)
        normal_ff[0] <= wdata_i[0]; // RULE15
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      sleep_ctl_ff <= RAIL3_SLEEP_CONTROL_RST; // RULE2
    else if (wr_sleep)
      sleep_ctl_ff <= wdata_i; // RULE2
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rail3_asleep_ff <= 1'b0;
    else
      rail3_asleep_ff <= rail3_sleep_req;
  end

  // ----------------------------------------------------------------
  // Rail four and five control registers
  // ----------------------------------------------------------------
  logic [5:0] ctl_ff [NUM_CTL_RAILS];

  for (genvar i = 0; i < NUM_CTL_RAILS; i++)
  begin : g_rail
    logic [7:0] offs;
    logic pin;
    assign offs = (i == 0) ? RAIL4_CONTROL_OFFS : RAIL5_CONTROL_OFFS;
    assign pin = sleep_pin_sel_i[i+1] ? pin_sync[1] : pin_sync[0];

    // Bits 7-6 are not stored, so writes there are dropped
    always_ff @(posedge clk_i or posedge rst_i)
    begin
      if (rst_i)
        ctl_ff[i] <= RAIL_CONTROL_RST;
      else if (wr_en_i && (addr_i == offs))
        ctl_ff[i] <= wdata_i[5:0]; // RULE14
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        rail_sleep_o[i] <= 1'b0;
        rail_pwm_o[i] <= 1'b0;
        rail_on_o[i] <= 1'b0;
        rail_code_ignored_o[i] <= 1'b0;
      end
      else
      begin
        rail_sleep_o[i] <= (ctl_ff[i][SLEEP_ENABLE_MSB:SLEEP_ENABLE_LSB] != SLEEP_DISABLED)
                           && pin; // RULE5 RULE9
        rail_pwm_o[i] <= ctl_ff[i][OPERATING_MODE_BIT]; // RULE7 RULE11
        // Register bit overrides the sequencer; it can only hold a rail off
        rail_on_o[i] <= ctl_ff[i][ON_CONTROL_BIT] && rail_seq_on_i[i]; // RULE8 RULE12
        // Flags host misuse of the code-use field
        rail_code_ignored_o[i] <= ctl_ff[i][CODE_USE_MSB:CODE_USE_LSB] != CODE_USE_KEEP; // RULE6 RULE10
      end
    end
  end

  // ----------------------------------------------------------------
  // Rail three outputs and read port
  // ----------------------------------------------------------------
  logic [7:0] nxt_rdata;

  always_comb
  begin
    case (addr_i)
      RAIL3_DECAY_OFFS: nxt_rdata = decay_ff;
      RAIL3_NORMAL_VOLTAGE_OFFS: nxt_rdata = normal_ff;
      RAIL3_SLEEP_CONTROL_OFFS: nxt_rdata = sleep_ctl_ff;
      RAIL4_CONTROL_OFFS: nxt_rdata = {2'h0, ctl_ff[0]}; // RULE14
      RAIL5_CONTROL_OFFS: nxt_rdata = {2'h0, ctl_ff[1]}; // RULE14
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (rd_en_i)
      rdata_o <= nxt_rdata;
  end

  // Sleep code drives the rail while asleep even if rewritten meanwhile
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rail3_voltage_code_o <= RAIL3_NORMAL_VOLTAGE_RST[CODE_MSB:CODE_LSB];
      rail3_sleep_o <= 1'b0;
      rail3_decay_select_o <= 1'b0;
    end
    else
    begin
      rail3_voltage_code_o <= rail3_asleep_ff ? sleep_ctl_ff[CODE_MSB:CODE_LSB]
                                              : normal_ff[CODE_MSB:CODE_LSB]; // RULE1
      rail3_sleep_o <= rail3_asleep_ff; // RULE4
      rail3_decay_select_o <= decay_ff[RAIL3_DECAY_BIT]; // RULE13
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_normal_write;
    wr_normal && !rail3_enter |=> normal_ff[7:1] == $past(wdata_i[7:1]);
  endproperty
  a_normal_write: assert property (p_normal_write) // RULE1
    else $error("normal code write not stored");

  property p_sleep_write;
    wr_sleep |=> sleep_ctl_ff == $past(wdata_i);
  endproperty
  a_sleep_write: assert property (p_sleep_write) // RULE2
    else $error("sleep control write not stored");

  property p_copy;
    rail3_enter |=> normal_ff[7:1] == $past(sleep_ctl_ff[7:1]);
  endproperty
  a_copy: assert property (p_copy) // RULE3
    else $error("sleep code not copied on entry");

  property p_r3_sleep_off;
    !sleep_ctl_ff[0] [*2] |=> !rail3_sleep_o;
  endproperty
  a_r3_sleep_off: assert property (p_r3_sleep_off) // RULE4
    else $error("rail three asleep while disabled");

  property p_r4_sleep_off;
    ctl_ff[0][5:4] == 2'h0 |=> !rail_sleep_o[0];
  endproperty
  a_r4_sleep_off: assert property (p_r4_sleep_off) // RULE5
    else $error("rail four asleep while disabled");

  property p_r4_mode;
    wr_en_i && addr_i == RAIL4_CONTROL_OFFS |=> ##1 rail_pwm_o[0] == $past(wdata_i[1], 2);
  endproperty
  a_r4_mode: assert property (p_r4_mode) // RULE7
    else $error("rail four mode not applied");

  property p_r4_off;
    wr_en_i && addr_i == RAIL4_CONTROL_OFFS && !wdata_i[0] |=> ##1 !rail_on_o[0];
  endproperty
  a_r4_off: assert property (p_r4_off) // RULE8
    else $error("rail four not forced off");

  property p_r5_sleep_off;
    ctl_ff[1][5:4] == 2'h0 |=> !rail_sleep_o[1];
  endproperty
  a_r5_sleep_off: assert property (p_r5_sleep_off) // RULE9
    else $error("rail five asleep while disabled");

  property p_r5_mode;
    wr_en_i && addr_i == RAIL5_CONTROL_OFFS |=> ##1 rail_pwm_o[1] == $past(wdata_i[1], 2);
  endproperty
  a_r5_mode: assert property (p_r5_mode) // RULE11
    else $error("rail five mode not applied");

  property p_r5_off;
    wr_en_i && addr_i == RAIL5_CONTROL_OFFS && !wdata_i[0] |=> ##1 !rail_on_o[1];
  endproperty
  a_r5_off: assert property (p_r5_off) // RULE12
    else $error("rail five not forced off");

  property p_decay;
    wr_decay |=> ##1 rail3_decay_select_o == $past(wdata_i[0], 2);
  endproperty
  a_decay: assert property (p_decay) // RULE13
    else $error("decay select not applied");

  property p_reserved_zero;
    rd_en_i && (addr_i == RAIL4_CONTROL_OFFS || addr_i == RAIL5_CONTROL_OFFS)
      |=> rdata_o[7:6] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // RULE14
    else $error("reserved bits read nonzero");

  property p_spare_bit;
    wr_normal ##1 !wr_normal ##1 (rd_en_i && addr_i == RAIL3_NORMAL_VOLTAGE_OFFS && !wr_normal)
      |=> rdata_o[0] == $past(wdata_i[0], 3);
  endproperty
  a_spare_bit: assert property (p_spare_bit) // RULE15
    else $error("spare bit not read back");

endmodule

// >>> tb/brc_host_model.sv
// Host model issuing register writes and reads to the rail control bank
module brc_host_model (
  input wire logic clk_i, // Device clock
  input wire logic [7:0] rdata_i, // Read data from the bank
  output logic wr_en_o, // Write strobe
  output logic rd_en_o, // Read strobe
  output logic [7:0] addr_o, // Register offset
  output logic [7:0] wdata_o // Write data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Released lines show the inverse, so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_en_o = 1'b1;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask

  task automatic wr_ctl(input logic [7:0] a, input logic [7:0] d);
    wr(a, d | 8'h0c);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_en_o = 1'b1;
    @(negedge clk_i);
    rd_en_o = 1'b0;
    d = rdata_i;
    addr_o = ~a;
  endtask
endmodule

// >>> tb/tb.sv
// Self-checking testbench for the rail control register bank
module tb
  import brc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i, rst_i, wr_en, rd_en, pin_a, pin_b, slp3, decay3;
  logic [7:0] addr, wdata, rdata, rv, d;
  logic [2:0] sel;
  logic [1:0] seq, rsleep, pwm, on, ign;
  logic [6:0] code3;
  logic [31:0] rnd;
  int failures, checks_done, j;

  brc_rail_regs brc_rail_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .sleep_pin_a_i(pin_a),
    .sleep_pin_b_i(pin_b), .sleep_pin_sel_i(sel), .rail_seq_on_i(seq), .rdata_o(rdata),
    .rail3_voltage_code_o(code3), .rail3_sleep_o(slp3), .rail3_decay_select_o(decay3),
    .rail_sleep_o(rsleep), .rail_pwm_o(pwm), .rail_on_o(on), .rail_code_ignored_o(ign));

  brc_host_model brc_host_model_inst (.clk_i(clk_i), .rdata_i(rdata), .wr_en_o(wr_en),
    .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Upper two bits read zero, bits 3-2 always sent as 3h
  function automatic logic [7:0] ctl_exp(input logic [7:0] v);
    return (v | 8'h0c) & 8'h3f;
  endfunction

  function automatic logic slp_exp(input logic [1:0] en, input logic pin);
    return (en != 2'h0) && pin;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test;
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial
  begin
    #(40 * 20000);
    failures++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_i = 1'b1;
    pin_a = 1'b0;
    pin_b = 1'b0;
    sel = 3'b110;
    seq = 2'h3;
    rnd = 32'hdf89522c;
    failures = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    brc_host_model_inst.rd(RAIL3_NORMAL_VOLTAGE_OFFS, d);
    chk(d, 8'h70, "normal reset");
    brc_host_model_inst.rd(RAIL3_SLEEP_CONTROL_OFFS, d);
    chk(d, 8'h70, "sleep reset");
    brc_host_model_inst.rd(RAIL4_CONTROL_OFFS, d);
    chk(d, 8'h0d, "rail4 reset");
    brc_host_model_inst.rd(RAIL5_CONTROL_OFFS, d);
    chk(d, 8'h0d, "rail5 reset");
    brc_host_model_inst.rd(RAIL3_DECAY_OFFS, d);
    chk(d, 8'h70, "decay reset");
    chk(8'(decay3), 8'h00, "decay select reset");
    chk(8'(code3), 8'h38, "code reset");
    chk(8'(on), 8'h03, "on reset");
    // Random traffic, sleep enable cycles through all four codes
    for (int k = 0; k < 24; k++)
    begin
      rnd = lfsr(rnd);
      rv = rnd[7:0];
      rv[5:4] = k[3:2];
      seq = rnd[9:8];
      pin_b = rnd[10];
      j = k % 4;
      if (j < 2)
      begin
        brc_host_model_inst.wr(8'h23 + 8'(j), rv);
        brc_host_model_inst.rd(8'h23 + 8'(j), d);
        chk(d, rv, "rail3 readback");
      end
      else
      begin
        j = j - 2;
        brc_host_model_inst.wr_ctl(8'h25 + 8'(j), rv);
        brc_host_model_inst.rd(8'h25 + 8'(j), d);
        chk(d, ctl_exp(rv), "ctl readback");
        chk(8'(pwm[j]), 8'(rv[1]), "pwm");
        chk(8'(on[j]), 8'(rv[0] & seq[j]), "on");
        chk(8'(rsleep[j]), 8'(slp_exp(rv[5:4], pin_b)), "sleep");
        chk(8'(ign[j]), 8'h00, "ignored");
      end
    end
    brc_host_model_inst.wr(8'h30, 8'hff);
    brc_host_model_inst.rd(8'h30, d);
    chk(d, 8'h00, "unmapped");
    // Sleep entry copies the sleep code into the normal code
    pin_b = 1'b0;
    sel = 3'b000;
    brc_host_model_inst.wr(RAIL3_NORMAL_VOLTAGE_OFFS, 8'h11);
    brc_host_model_inst.wr(RAIL3_SLEEP_CONTROL_OFFS, 8'h55);
    pin_a = 1'b1;
    repeat (6) @(negedge clk_i);
    chk(8'({slp3, code3}), 8'haa, "asleep");
    chk(8'(rsleep), 8'h03, "rails four five on pin a");
    brc_host_model_inst.rd(RAIL3_NORMAL_VOLTAGE_OFFS, d);
    chk(d, 8'h55, "copied code");
    pin_a = 1'b0;
    repeat (6) @(negedge clk_i);
    chk(8'({slp3, code3}), 8'h2a, "awake");
    brc_host_model_inst.wr(RAIL3_SLEEP_CONTROL_OFFS, 8'h54);
    pin_a = 1'b1;
    repeat (6) @(negedge clk_i);
    chk(8'(slp3), 8'h00, "sleep disabled");
    pin_a = 1'b0;
    sel = 3'b001;
    brc_host_model_inst.wr(RAIL3_SLEEP_CONTROL_OFFS, 8'h13);
    pin_b = 1'b1;
    repeat (6) @(negedge clk_i);
    chk(8'({slp3, code3}), 8'h89, "pin b sleep");
    pin_b = 1'b0;
    // Decay select and a misused code-use field
    brc_host_model_inst.wr(RAIL3_DECAY_OFFS, 8'h01);
    repeat (2) @(negedge clk_i);
    chk(8'(decay3), 8'h01, "decay set");
    brc_host_model_inst.wr(RAIL3_DECAY_OFFS, 8'h00);
    repeat (2) @(negedge clk_i);
    chk(8'(decay3), 8'h00, "decay clear");
    brc_host_model_inst.wr(RAIL4_CONTROL_OFFS, 8'h05);
    repeat (2) @(negedge clk_i);
    chk(8'(ign), 8'h01, "codes ignored");
    end_of_test();
  end
endmodule
